// ### hdl/eepi_top.sv
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - option byte changes only in special modes
// - high voltage waits for latch set in an earlier write
// - latch and voltage set together sets neither
// - array writes ignored while voltage on
// - voltage without captured location changes nothing
// - erased reads one, programming only clears
// - protect set at reset, clear within 64
// - protection set again stays until reset
// - byte and row bits choose erase extent
// - erase bit selects erase versus program
// - latch captures writes and hides array reads
// - thirty-two rows of sixteen bytes
module eepi_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mode_special_pin,
  output logic hv_enable_out,
  output logic latch_active_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [eepi_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [eepi_pkg::PROT_W-1:0] prot_ff, nxt_prot;
  logic [eepi_pkg::PROT_W-1:0] lock_ff, nxt_lock;
  logic [eepi_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic cap_ff, nxt_cap;
  logic cap_opt_ff, nxt_cap_opt;
  logic [8:0] cap_addr_ff, nxt_cap_addr;
  logic [7:0] cap_data_ff, nxt_cap_data;
  logic wr_pend_ff, nxt_wr_pend;
  logic [12:0] wr_addr_ff, nxt_wr_addr;
  logic rd_pend_ff, nxt_rd_pend;
  logic [12:0] rd_addr_ff, nxt_rd_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hready_ff, nxt_hready;
  logic mode_meta_ff, mode_ff;
  logic fire;
  logic [7:0] arr_rd;
  logic [7:0] opt_rd;

  function automatic logic is_arr(input logic [12:0] a);
    is_arr = (a[eepi_pkg::ARR_REG_MSB:eepi_pkg::ARR_REG_LSB] == eepi_pkg::ARR_REGION);
  endfunction

  function automatic logic [8:0] arr_idx(input logic [12:0] a);
    arr_idx = a[eepi_pkg::ARR_IDX_MSB:eepi_pkg::ARR_IDX_LSB];
  endfunction

  // ---------------------------------------------------------------
  // mode strap synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_meta_ff <= 1'b0;
      mode_ff <= 1'b0;
    end
    else
    begin
      mode_meta_ff <= mode_special_pin;
      mode_ff <= mode_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // bus slave: writes land in the data phase, reads take one wait
  // ---------------------------------------------------------------
  // the read wait lets a write just ahead of a read settle first
  always_comb
  begin
    logic take;
    take = hsel && htrans[1] && hready;
    nxt_wr_pend = take && hwrite;
    nxt_wr_addr = take ? haddr[12:0] : wr_addr_ff;
    nxt_rd_pend = take && !hwrite;
    nxt_rd_addr = (take && !hwrite) ? haddr[12:0] : rd_addr_ff;
    nxt_hready = !(take && !hwrite);
    nxt_hrdata = hrdata_ff;
    if (rd_pend_ff)
    begin
      nxt_hrdata = 32'h0000_0000;
      if (is_arr(rd_addr_ff))
        nxt_hrdata[7:0] = ctrl_ff[eepi_pkg::CB_LAT] ? 8'h00 : arr_rd;
      else
      begin
        case (rd_addr_ff)
          eepi_pkg::OFF_CTRL: nxt_hrdata[eepi_pkg::CTRL_W-1:0] = ctrl_ff;
          eepi_pkg::OFF_PROT: nxt_hrdata[eepi_pkg::PROT_W-1:0] = prot_ff;
          eepi_pkg::OFF_STAT:
          begin
            nxt_hrdata[eepi_pkg::SB_CAP] = cap_ff;
            nxt_hrdata[eepi_pkg::SB_MODE] = mode_ff;
            nxt_hrdata[eepi_pkg::SB_WIN] = (cnt_ff < eepi_pkg::BP_WINDOW);
          end
          eepi_pkg::OFF_OPT: nxt_hrdata[7:0] = opt_rd;
          default: nxt_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rd_pend_ff <= nxt_rd_pend;
      rd_addr_ff <= nxt_rd_addr;
      hready_ff <= nxt_hready;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ---------------------------------------------------------------
  // program control interlock and capture latches
  // ---------------------------------------------------------------
  always_comb
  begin
    logic lat_new;
    logic hv_new;
    lat_new = 1'b0;
    hv_new = 1'b0;
    nxt_ctrl = ctrl_ff;
    nxt_cap = cap_ff;
    nxt_cap_opt = cap_opt_ff;
    nxt_cap_addr = cap_addr_ff;
    nxt_cap_data = cap_data_ff;
    fire = 1'b0;
    if (wr_pend_ff && wr_addr_ff == eepi_pkg::OFF_CTRL)
    begin
      lat_new = hwdata[eepi_pkg::CB_LAT];
      hv_new = hwdata[eepi_pkg::CB_HV];
      if (lat_new && hv_new && !ctrl_ff[eepi_pkg::CB_LAT] && !ctrl_ff[eepi_pkg::CB_HV])
      begin
        lat_new = 1'b0;
        hv_new = 1'b0;
      end
      if (!ctrl_ff[eepi_pkg::CB_LAT] || !lat_new)
        hv_new = 1'b0;
      nxt_ctrl = hwdata[eepi_pkg::CTRL_W-1:0];
      nxt_ctrl[eepi_pkg::CB_LAT] = lat_new;
      nxt_ctrl[eepi_pkg::CB_HV] = hv_new;
      // operation runs once, on the rising edge of the voltage bit
      fire = hv_new && !ctrl_ff[eepi_pkg::CB_HV] && cap_ff;
      if (!lat_new)
        nxt_cap = 1'b0;
    end
    else if (wr_pend_ff && ctrl_ff[eepi_pkg::CB_LAT] && !ctrl_ff[eepi_pkg::CB_HV]
             && (is_arr(wr_addr_ff) || wr_addr_ff == eepi_pkg::OFF_OPT))
    begin
      nxt_cap = 1'b1;
      nxt_cap_opt = !is_arr(wr_addr_ff);
      nxt_cap_addr = arr_idx(wr_addr_ff);
      nxt_cap_data = hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= eepi_pkg::CTRL_RST;
      cap_ff <= 1'b0;
      cap_opt_ff <= 1'b0;
      cap_addr_ff <= '0;
      cap_data_ff <= 8'h00;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      cap_ff <= nxt_cap;
      cap_opt_ff <= nxt_cap_opt;
      cap_addr_ff <= nxt_cap_addr;
      cap_data_ff <= nxt_cap_data;
    end
  end

  // ---------------------------------------------------------------
  // block protection with post-reset clear window
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cnt = (cnt_ff < eepi_pkg::BP_WINDOW) ? cnt_ff + 7'h01 : cnt_ff;
    nxt_prot = prot_ff;
    nxt_lock = lock_ff;
    if (wr_pend_ff && wr_addr_ff == eepi_pkg::OFF_PROT)
    begin
      for (int i = 0; i < eepi_pkg::PROT_W; i++)
      begin
        if (hwdata[i])
        begin
          nxt_prot[i] = 1'b1;
          if (!prot_ff[i])
            nxt_lock[i] = 1'b1;
        end
        else if (cnt_ff < eepi_pkg::BP_WINDOW && !lock_ff[i])
          nxt_prot[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= '0;
      prot_ff <= eepi_pkg::PROT_RST;
      lock_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      prot_ff <= nxt_prot;
      lock_ff <= nxt_lock;
    end
  end

  // ---------------------------------------------------------------
  // array storage
  // ---------------------------------------------------------------
  eepi_array u_array (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(fire),
    .erase(nxt_ctrl[eepi_pkg::CB_ERA]),
    .row_sel(nxt_ctrl[eepi_pkg::CB_ROW]),
    .byte_sel(nxt_ctrl[eepi_pkg::CB_BYTE]),
    .opt_sel(cap_opt_ff),
    .opt_allow(mode_ff && !prot_ff[eepi_pkg::PB_OPT]),
    .addr(cap_addr_ff),
    .data(cap_data_ff),
    .prot_lo(prot_ff[eepi_pkg::PB_LO]),
    .prot_hi(prot_ff[eepi_pkg::PB_HI]),
    .rd_idx(arr_idx(rd_addr_ff)),
    .rd_data(arr_rd),
    .opt_data(opt_rd)
  );

  // outputs straight from flip-flops; response is always OKAY
  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign hv_enable_out = ctrl_ff[eepi_pkg::CB_HV];
  assign latch_active_out = ctrl_ff[eepi_pkg::CB_LAT];
endmodule // eepi_top

// ### hdl/eepi_pkg.sv
package eepi_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets inside the slave window)
  // ---------------------------------------------------------------
  localparam int unsigned LADDR_W = 13;
  localparam logic [12:0] OFF_CTRL = 13'h0000;
  localparam logic [12:0] OFF_PROT = 13'h0004;
  localparam logic [12:0] OFF_STAT = 13'h0008;
  localparam logic [12:0] OFF_OPT = 13'h0010;
  // array window 0x0800..0x0fff, one byte per word
  localparam logic [1:0] ARR_REGION = 2'h1;
  localparam int unsigned ARR_REG_MSB = 12;
  localparam int unsigned ARR_REG_LSB = 11;
  localparam int unsigned ARR_IDX_MSB = 10;
  localparam int unsigned ARR_IDX_LSB = 2;

  // ---------------------------------------------------------------
  // program control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CB_HV = 0;
  localparam int unsigned CB_LAT = 1;
  localparam int unsigned CB_ERA = 2;
  localparam int unsigned CB_ROW = 3;
  localparam int unsigned CB_BYTE = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // ---------------------------------------------------------------
  // block protect register fields
  // ---------------------------------------------------------------
  localparam int unsigned PROT_W = 3;
  localparam int unsigned PB_LO = 0;
  localparam int unsigned PB_HI = 1;
  localparam int unsigned PB_OPT = 2;
  localparam logic [PROT_W-1:0] PROT_RST = 3'h7;
  localparam int unsigned BP_WINDOW_CYCLES = 64;
  localparam int unsigned CNT_W = 7;
  localparam logic [CNT_W-1:0] BP_WINDOW = 7'h40;

  // status register fields
  localparam int unsigned SB_CAP = 0;
  localparam int unsigned SB_MODE = 1;
  localparam int unsigned SB_WIN = 2;

  // ---------------------------------------------------------------
  // array organisation
  // ---------------------------------------------------------------
  localparam int unsigned ARR_DEPTH = 512;
  localparam int unsigned ARR_AW = 9;
  localparam int unsigned ROW_LSB = 4;
  localparam int unsigned HALF_BIT = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

// ### hdl/eepi_array.sv
`timescale 1ns/10ps
module eepi_array (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic erase,
  input wire logic row_sel,
  input wire logic byte_sel,
  input wire logic opt_sel,
  input wire logic opt_allow,
  input wire logic [8:0] addr,
  input wire logic [7:0] data,
  input wire logic prot_lo,
  input wire logic prot_hi,
  input wire logic [8:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [7:0] opt_data
);
  logic [7:0] mem_ff [0:eepi_pkg::ARR_DEPTH-1];
  logic [7:0] nxt_mem [0:eepi_pkg::ARR_DEPTH-1];
  logic [7:0] opt_ff;
  logic [7:0] nxt_opt;

  // ---------------------------------------------------------------
  // cell update: erase sets ones, program only clears bits
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [8:0] idx;
    logic hit;
    logic locked;
    idx = '0;
    hit = 1'b0;
    locked = 1'b0;
    for (int i = 0; i < eepi_pkg::ARR_DEPTH; i++)
    begin
      idx = i[8:0];
      locked = idx[eepi_pkg::HALF_BIT] ? prot_hi : prot_lo;
      if (!erase)
        hit = (idx == addr);
      else if (byte_sel)
        hit = (idx == addr);
      else if (row_sel)
        hit = (idx[8:eepi_pkg::ROW_LSB] == addr[8:eepi_pkg::ROW_LSB]);
      else
        hit = 1'b1;
      nxt_mem[i] = mem_ff[i];
      if (go && !opt_sel && hit && !locked)
        nxt_mem[i] = erase ? eepi_pkg::ERASED_BYTE : (mem_ff[i] & data);
    end
    nxt_opt = opt_ff;
    if (go && opt_sel && opt_allow)
      nxt_opt = erase ? eepi_pkg::ERASED_BYTE : (opt_ff & data);
  end

  // erased contents at reset keep simulation free of unknowns
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < eepi_pkg::ARR_DEPTH; i++)
        mem_ff[i] <= eepi_pkg::ERASED_BYTE;
      opt_ff <= eepi_pkg::ERASED_BYTE;
    end
    else
    begin
      for (int i = 0; i < eepi_pkg::ARR_DEPTH; i++)
        mem_ff[i] <= nxt_mem[i];
      opt_ff <= nxt_opt;
    end
  end

  assign rd_data = mem_ff[rd_idx];
  assign opt_data = opt_ff;
endmodule // eepi_array

// ### sim/eepi_top_monitor.sv
`timescale 1ns/10ps
// port watcher; outputs tied to their causes
module eepi_top_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic hv_enable_out,
  input wire logic latch_active_out
);
  logic wr_ctl_ff;
  logic nxt_wr_ctl;
  // control write in its data phase
  always_comb
  begin
    nxt_wr_ctl = hsel && htrans[1] && hready && hwrite && haddr[12:0] == eepi_pkg::OFF_CTRL;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ctl_ff <= 1'b0;
    else
      wr_ctl_ff <= nxt_wr_ctl;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (rd_take |=> rd_answer) else $error("read wait not one cycle");
  write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stalled");
  hv_latch_a: assert property ($rose(hv_enable_out) |-> latch_active_out && $past(latch_active_out))
    else $error("voltage without prior latch");
  joint_set_a: assert property ($rose(hv_enable_out) |-> !$rose(latch_active_out))
    else $error("latch and voltage set together");
  hv_cause_a: assert property (!$stable(hv_enable_out) |-> $past(wr_ctl_ff))
    else $error("voltage moved without control write");
  latch_cause_a: assert property (!$stable(latch_active_out) |-> $past(wr_ctl_ff))
    else $error("latch moved without control write");
  hv_clear_a: assert property (wr_ctl_ff && !hwdata[0] |=> !hv_enable_out && latch_active_out == $past(hwdata[1]))
    else $error("control clear not applied");
endmodule // eepi_top_monitor
bind eepi_top eepi_top_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hv_enable_out(hv_enable_out), .latch_active_out(latch_active_out));

// ### sim/eepi_cpu.sv
`timescale 1ns/10ps
// processor core as bus master; released lines show inverted junk
module eepi_cpu (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer, waits on hready only
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // latch, location, voltage, then clear
  task automatic prog(input logic [31:0] a, input logic [7:0] d, input logic [4:0] c);
    logic [31:0] q;
    xfer(1'b1, 32'h0, {27'h0, c | 5'h02}, q);
    xfer(1'b1, a, {24'h0, d}, q);
    xfer(1'b1, 32'h0, {27'h0, c | 5'h03}, q);
    xfer(1'b1, 32'h0, 32'h0, q);
  endtask
endmodule // eepi_cpu

// ### sim/eepi_tb_top.sv
`timescale 1ns/10ps
module eepi_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic mode = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, hv, lat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  wire logic hready = hreadyout;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] m [512];
  logic [7:0] opt;
  logic [2:0] pr;
  logic [4:0] codes [4] = '{5'h14, 5'h1c, 5'h0c, 5'h04};
  initial forever #4 hclk = ~hclk;
  eepi_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_special_pin(mode), .hv_enable_out(hv), .latch_active_out(lat));
  eepi_cpu cpu (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    cpu.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task arr_all();
    for (int i = 0; i < 512; i++)
      rd(32'h800 + i * 4, {24'h0, m[i]});
  endtask
  task rst();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (m[i]) m[i] = 8'hff;
    opt = 8'hff;
    pr = 3'h7;
  endtask
  // drive one operation and mirror it in the model
  task op(input logic [4:0] c, input logic [12:0] a, input logic [7:0] d);
    logic [8:0] x;
    x = a[10:2];
    cpu.prog({19'h0, a}, d, c);
    if (a == eepi_pkg::OFF_OPT)
    begin
      if (mode && !pr[2]) opt = c[2] ? 8'hff : opt & d;
    end
    else
      for (int i = 0; i < 512; i++)
        if (!pr[i[8]] && (c[2] ? (c[4] ? i == x : (c[3] ? i[8:4] == x[8:4] : 1'b1)) : i == x))
          m[i] = c[2] ? 8'hff : m[i] & d;
  endtask
  initial
  begin
    void'($urandom(56201));
    rst();
    repeat (70) @(posedge hclk);
    wr(eepi_pkg::OFF_PROT, 32'h0);
    rd(eepi_pkg::OFF_PROT, 32'h7);
    rd(eepi_pkg::OFF_STAT, 32'h0);
    rst();
    wr(eepi_pkg::OFF_PROT, 32'h0);
    rd(eepi_pkg::OFF_PROT, 32'h0);
    rd(eepi_pkg::OFF_STAT, 32'h4);
    // re-set inside the open window, so only the lock can refuse the clear
    wr(eepi_pkg::OFF_PROT, 32'h2);
    wr(eepi_pkg::OFF_PROT, 32'h0);
    rd(eepi_pkg::OFF_PROT, 32'h2);
    rst();
    wr(eepi_pkg::OFF_PROT, 32'h0);
    pr = 3'h0;
    rd(32'h100, 32'h0);
    $display("protect window test done");
    wr(32'h0, 32'h3);
    rd(32'h0, 32'h0);
    wr(32'h800, 32'h0);
    wr(32'h0, 32'h2);
    rd(32'h800, 32'h0);
    wr(32'h0, 32'h3);
    wr(32'h0, 32'h0);
    arr_all();
    $display("sequence interlock test done");
    op(5'h0, eepi_pkg::OFF_OPT, 8'h5a);
    rd(eepi_pkg::OFF_OPT, {24'h0, opt});
    mode <= 1'b1;
    repeat (3) @(posedge hclk);
    op(5'h0, eepi_pkg::OFF_OPT, 8'h5a);
    rd(eepi_pkg::OFF_OPT, {24'h0, opt});
    op(5'h04, eepi_pkg::OFF_OPT, 8'h0);
    rd(eepi_pkg::OFF_OPT, {24'h0, opt});
    wr(eepi_pkg::OFF_PROT, 32'h4);
    wr(eepi_pkg::OFF_PROT, 32'h0);
    rd(eepi_pkg::OFF_PROT, 32'h4);
    pr = 3'h4;
    $display("option and lock test done");
    repeat (6)
    begin
      op(5'h0, 13'h800 + ($urandom % 512) * 4, $urandom);
      arr_all();
    end
    wr(32'h0, 32'h2);
    wr(32'h800, 32'h3c);
    rd(eepi_pkg::OFF_STAT, 32'h3);
    wr(32'h0, 32'h3);
    @(posedge hclk);
    chk({30'h0, hv, lat}, 32'h3);
    wr(32'h804, 32'h0);
    // re-fire the held location: a capture taken under voltage would show up here
    wr(32'h0, 32'h2);
    wr(32'h0, 32'h3);
    wr(32'h0, 32'h0);
    m[0] = m[0] & 8'h3c;
    arr_all();
    $display("program test done");
    foreach (codes[k])
    begin
      op(codes[k], 13'h800 + ($urandom % 512) * 4, 8'h0);
      arr_all();
    end
    $display("erase test done");
    finish_test();
  end
endmodule // eepi_tb_top
